// ### src/umspi_baud.sv
`timescale 1ns/1ps
`default_nettype none
`include "umspi_cfg.svh"

module umspi_baud (
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   input wire logic enable_i,
   input wire logic [11:0] divisor_i,
   input wire logic reload_i,
   output logic tick_o
);
   import umspi_pkg::*;

   umspi_baud_t b_reg;
   umspi_baud_t b_next;

   // ==========================================================
   // half-bit divider: one tick every divisor+1 cycles
   always_comb
   begin
      b_next = b_reg;
      tick_o = enable_i && (b_reg.cnt == 12'h000); // RULE_06
      // held at the divisor while off, so a zero divisor ticks at once on enable
      if (reload_i || !enable_i) // RULE_22 RULE_16
      begin
         b_next.cnt = divisor_i;
      end
      else if (b_reg.cnt == 12'h000)
      begin
         b_next.cnt = divisor_i;
      end
      else
      begin
         b_next.cnt = b_reg.cnt - 12'h001;
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         b_reg.cnt <= `UMSPI_DIV_RST;
      end
      else
      begin
         b_reg <= b_next;
      end
   end

endmodule
`default_nettype wire

// ### src/umspi_cfg.svh
`ifndef UMSPI_CFG_SVH
`define UMSPI_CFG_SVH

// ==========================================================
// register indices (byte address is four times the index)
`define UMSPI_IDX_STATUS 10'h0C0
`define UMSPI_IDX_CTRL_B 10'h0C1
`define UMSPI_IDX_CTRL_C 10'h0C2
`define UMSPI_IDX_PIN 10'h0C3
`define UMSPI_IDX_DIV_LO 10'h0C4
`define UMSPI_IDX_DIV_HI 10'h0C5
`define UMSPI_IDX_DATA 10'h0C6

// ==========================================================
// field positions
`define UMSPI_BIT_RXC 7
`define UMSPI_BIT_TXC 6
`define UMSPI_BIT_TXE 5
`define UMSPI_BIT_RXEN 4
`define UMSPI_BIT_TXEN 3
`define UMSPI_BIT_ORDER 2
`define UMSPI_BIT_PHASE 1
`define UMSPI_BIT_POL 0
`define UMSPI_BIT_DIR 0

// ==========================================================
// reset values and fixed codes
`define UMSPI_CTRL_B_RST 8'h00
`define UMSPI_CTRL_C_RST 8'h06
`define UMSPI_CTRL_B_WMASK 8'hFD
`define UMSPI_DIV_RST 12'h000
`define UMSPI_MODE_MSPI 2'b11
`define UMSPI_EDGE_LAST 4'hF

`endif

// ### src/umspi_pkg.sv
`include "umspi_cfg.svh"

package umspi_pkg;

   typedef enum logic [0:0] {UMSPI_IDLE, UMSPI_XFER} umspi_state_t;

   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } umspi_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
   } umspi_apb_rsp_t;

   typedef struct packed {
      umspi_state_t state;
      logic [7:0] ctrl_b;
      logic [7:0] ctrl_c;
      logic dir;
      logic [7:0] div_lo;
      logic [3:0] div_hi;
      logic [7:0] tx_buf;
      logic tx_full;
      logic [7:0] tx_sh;
      logic [7:0] rx_sh;
      logic [7:0] rx_buf;
      logic rxc;
      logic txc;
      logic [3:0] edge_cnt;
      logic sck;
      logic mosi;
      logic in_s1;
      logic in_s2;
      logic in_s3;
      logic in_f;
      logic [31:0] prdata;
      logic pslverr;
   } umspi_core_t;

   typedef struct packed {
      logic [11:0] cnt;
   } umspi_baud_t;

endpackage

// ### src/umspi_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "umspi_cfg.svh"

// Notes on behaviour
// RULE_01: master spi operation starts only when both mode select bits are one
// RULE_02: parity, recovery and separate rx/tx control unused; one shared transfer engine
// RULE_03: pin override and flag behaviour same as in normal serial operation
// RULE_04: only internal clocking; clock pin direction must be output to transfer
// RULE_05: software sets clock pin direction before enabling transmitter or receiver
// RULE_06: bit rate is system clock over twice divisor plus one
// RULE_07: the same baud generator serves synchronous master and spi operation
// RULE_08: high divisor register holds divisor bits 11:8 in bits 3:0
// RULE_09: polarity and phase pick modes 0..3 with given sample/setup edges
// RULE_10: data shifts out and latches in on opposite clock edges
// RULE_11: changing polarity, phase or order mid-transfer corrupts it; change when idle
// RULE_12: every frame is exactly eight bits, msb or lsb first
// RULE_13: transmitter and receiver share one bit order setting
// RULE_14: after a frame, next queued frame follows at once or line idles high
// RULE_15: two data writes go back to back; transmit complete after both
// RULE_16: divisor zero at transmitter enable starts clock at once; set later
// RULE_17: baud divisor resets to zero
// RULE_18: transmitter may run alone; receiver needs transmitter enabled
// RULE_19: software keeps global interrupts off during initialization
// RULE_20: software checks completion flags and clears transmit complete before writes
// RULE_21: bit order set sends lsb first, clear sends msb first
// RULE_22: writing low divisor reloads the prescaler at once
// RULE_23: data register write starts a full-duplex transfer
// RULE_24: frame error, overrun and parity flags always read zero
// RULE_25: between frames the clock rests at the polarity idle level
module umspi_top (
   input wire logic core_clk_i,
   input wire logic arst_n_i,
   input wire umspi_pkg::umspi_apb_req_t apb_i,
   output var umspi_pkg::umspi_apb_rsp_t apb_o,
   input wire logic serial_in_i,
   output logic serial_out_o,
   output logic serial_out_oe_n_o,
   output logic sck_o,
   output logic sck_oe_n_o
);
   import umspi_pkg::*;

   umspi_core_t st_reg;
   umspi_core_t st_next;
   logic [9:0] idx;
   logic setup;
   logic access;
   logic master;
   logic busy;
   logic rx_on;
   logic pha;
   logic pol;
   logic lsb;
   logic baud_en;
   logic baud_tick;
   logic div_lo_wr;

   // ==========================================================
   // helpers
   function automatic logic is_mapped(input logic [9:0] i);
      return (i >= `UMSPI_IDX_STATUS) && (i <= `UMSPI_IDX_DATA);
   endfunction

   function automatic logic out_bit(input logic [7:0] sh, input logic l);
      return l ? sh[0] : sh[7]; // RULE_21
   endfunction

   function automatic logic [7:0] shift_out(input logic [7:0] sh, input logic l);
      return l ? {1'b0, sh[7:1]} : {sh[6:0], 1'b0}; // RULE_13
   endfunction

   function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic b,
                                           input logic l);
      return l ? {b, sh[7:1]} : {sh[6:0], b}; // RULE_13
   endfunction

   // moves the buffered byte into the shifter; phase 0 needs its first bit out early
   function automatic umspi_core_t load_frame(input umspi_core_t s);
      umspi_core_t r;
      r = s;
      r.tx_sh = s.tx_buf;
      r.tx_full = 1'b0;
      r.edge_cnt = 4'h0;
      r.state = UMSPI_XFER;
      if (!s.ctrl_c[`UMSPI_BIT_PHASE])
      begin
         r.mosi = out_bit(s.tx_buf, s.ctrl_c[`UMSPI_BIT_ORDER]);
         r.tx_sh = shift_out(s.tx_buf, s.ctrl_c[`UMSPI_BIT_ORDER]);
      end
      return r;
   endfunction

   // ==========================================================
   // decode
   assign idx = apb_i.paddr[11:2];
   assign setup = apb_i.psel && !apb_i.penable;
   assign access = apb_i.psel && apb_i.penable;
   assign master = (st_reg.ctrl_c[7:6] == `UMSPI_MODE_MSPI) && st_reg.dir; // RULE_01 RULE_04
   assign busy = (st_reg.state == UMSPI_XFER);
   assign rx_on = st_reg.ctrl_b[`UMSPI_BIT_RXEN] && st_reg.ctrl_b[`UMSPI_BIT_TXEN]; // RULE_18
   assign pha = st_reg.ctrl_c[`UMSPI_BIT_PHASE];
   assign pol = st_reg.ctrl_c[`UMSPI_BIT_POL];
   assign lsb = st_reg.ctrl_c[`UMSPI_BIT_ORDER];
   assign div_lo_wr = access && apb_i.pwrite && (idx == `UMSPI_IDX_DIV_LO);
   // a disabled transmitter keeps running until its pending bytes are out
   assign baud_en = master && (st_reg.ctrl_b[`UMSPI_BIT_TXEN] || busy || st_reg.tx_full);

   // ==========================================================
   // shared baud generator
   umspi_baud u_baud ( // RULE_07
      .core_clk_i(core_clk_i),
      .arst_n_i(arst_n_i),
      .enable_i(baud_en),
      .divisor_i({st_reg.div_hi, st_reg.div_lo}),
      .reload_i(div_lo_wr),
      .tick_o(baud_tick)
   );

   // ==========================================================
   // next state
   always_comb
   begin
      st_next = st_reg;

      // input sync: first stage feeds only the second
      st_next.in_s1 = serial_in_i;
      st_next.in_s2 = st_reg.in_s1;
      st_next.in_s3 = st_reg.in_s2;
      if (st_reg.in_s2 == st_reg.in_s3)
      begin
         st_next.in_f = st_reg.in_s3;
      end

      // register bus: read data is captured in the setup cycle
      if (setup)
      begin
         st_next.pslverr = !is_mapped(idx);
         case (idx)
            `UMSPI_IDX_STATUS: st_next.prdata = {24'h00_0000, st_reg.rxc, st_reg.txc,
                                                 !st_reg.tx_full, 5'b0_0000}; // RULE_24 RULE_03
            `UMSPI_IDX_CTRL_B: st_next.prdata = {24'h00_0000, st_reg.ctrl_b};
            `UMSPI_IDX_CTRL_C: st_next.prdata = {24'h00_0000, st_reg.ctrl_c};
            `UMSPI_IDX_PIN: st_next.prdata = {31'h0000_0000, st_reg.dir};
            `UMSPI_IDX_DIV_LO: st_next.prdata = {24'h00_0000, st_reg.div_lo};
            `UMSPI_IDX_DIV_HI: st_next.prdata = {28'h000_0000, st_reg.div_hi}; // RULE_08
            `UMSPI_IDX_DATA: st_next.prdata = {24'h00_0000, st_reg.rx_buf};
            default: st_next.prdata = 32'h0000_0000;
         endcase
      end

      if (access && apb_i.pwrite && is_mapped(idx))
      begin
         case (idx)
            `UMSPI_IDX_STATUS:
            begin
               if (apb_i.pwdata[`UMSPI_BIT_TXC]) // RULE_20
               begin
                  st_next.txc = 1'b0;
               end
            end
            `UMSPI_IDX_CTRL_B: st_next.ctrl_b = apb_i.pwdata[7:0] & `UMSPI_CTRL_B_WMASK;
            `UMSPI_IDX_CTRL_C: st_next.ctrl_c = apb_i.pwdata[7:0]; // RULE_11
            `UMSPI_IDX_PIN: st_next.dir = apb_i.pwdata[`UMSPI_BIT_DIR];
            `UMSPI_IDX_DIV_LO: st_next.div_lo = apb_i.pwdata[7:0];
            `UMSPI_IDX_DIV_HI: st_next.div_hi = apb_i.pwdata[3:0]; // RULE_08
            `UMSPI_IDX_DATA:
            begin
               // a write while the buffer is full is dropped; the empty flag warns
               if (st_reg.ctrl_b[`UMSPI_BIT_TXEN] && !st_reg.tx_full) // RULE_23 RULE_15
               begin
                  st_next.tx_buf = apb_i.pwdata[7:0];
                  st_next.tx_full = 1'b1;
               end
            end
            default: st_next.dir = st_reg.dir;
         endcase
      end

      if (access && !apb_i.pwrite && (idx == `UMSPI_IDX_DATA))
      begin
         st_next.rxc = 1'b0;
      end

      // shared transfer engine, sets come after clears so an event wins
      if (!master) // RULE_02
      begin
         st_next.state = UMSPI_IDLE;
         st_next.sck = pol; // RULE_25
         st_next.mosi = 1'b1;
      end
      else
      begin
         case (st_reg.state)
            UMSPI_IDLE:
            begin
               st_next.sck = pol; // RULE_25
               st_next.mosi = 1'b1; // RULE_14
               if (baud_tick && st_next.tx_full) // RULE_23
               begin
                  st_next = load_frame(st_next);
               end
            end
            UMSPI_XFER:
            begin
               if (baud_tick) // RULE_06
               begin
                  st_next.sck = !st_reg.sck;
                  st_next.edge_cnt = st_reg.edge_cnt + 4'h1;
                  // even edges lead; phase 0 samples leading, phase 1 trailing
                  if (!st_reg.edge_cnt[0] ^ pha) // RULE_09 RULE_10
                  begin
                     st_next.rx_sh = shift_in(st_reg.rx_sh, st_reg.in_f, lsb);
                  end
                  else if (pha || (st_reg.edge_cnt != `UMSPI_EDGE_LAST)) // RULE_10
                  begin
                     st_next.mosi = out_bit(st_reg.tx_sh, lsb);
                     st_next.tx_sh = shift_out(st_reg.tx_sh, lsb);
                  end
                  if (st_reg.edge_cnt == `UMSPI_EDGE_LAST) // RULE_12
                  begin
                     // overrun keeps the unread byte and drops the new one
                     if (rx_on && !st_next.rxc) // RULE_18
                     begin
                        st_next.rx_buf = st_next.rx_sh;
                        st_next.rxc = 1'b1;
                     end
                     if (st_next.tx_full) // RULE_14 RULE_15
                     begin
                        st_next = load_frame(st_next);
                     end
                     else
                     begin
                        // idle high follows a cycle later, never on a phase-1 sampling edge
                        st_next.state = UMSPI_IDLE;
                        st_next.txc = 1'b1; // RULE_15
                     end
                  end
               end
            end
            default: st_next.state = UMSPI_IDLE;
         endcase
      end
   end

   always_ff @(posedge core_clk_i or negedge arst_n_i)
   begin
      if (!arst_n_i)
      begin
         st_reg <= '0;
         st_reg.state <= UMSPI_IDLE;
         st_reg.ctrl_b <= `UMSPI_CTRL_B_RST;
         st_reg.ctrl_c <= `UMSPI_CTRL_C_RST;
         st_reg.div_lo <= 8'(`UMSPI_DIV_RST);
         st_reg.div_hi <= 4'(`UMSPI_DIV_RST >> 8); // RULE_17
         st_reg.mosi <= 1'b1;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   // ==========================================================
   // outputs
   assign apb_o = '{prdata: st_reg.prdata, pready: 1'b1, pslverr: st_reg.pslverr};
   assign serial_out_o = st_reg.mosi;
   // transmitter owns the data pin in master mode while enabled or mid-frame
   assign serial_out_oe_n_o = !(master && (st_reg.ctrl_b[`UMSPI_BIT_TXEN] || busy)); // RULE_03
   assign sck_o = st_reg.sck;
   assign sck_oe_n_o = !st_reg.dir; // RULE_04

   // ==========================================================
   // checks
   AST_MODE_GATES_START: // RULE_01
   assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      (st_reg.state == UMSPI_IDLE) ##1 (st_reg.state == UMSPI_XFER)
      |-> ($past(st_reg.ctrl_c[7:6]) == `UMSPI_MODE_MSPI))
      else $error("frame started outside master spi mode");

   AST_DIR_GATES_START: // RULE_04
   assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      (st_reg.state == UMSPI_IDLE) ##1 (st_reg.state == UMSPI_XFER) |-> $past(st_reg.dir))
      else $error("frame started with clock pin not an output");

   AST_SCK_TOGGLES_ON_TICK: // RULE_06
   assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      (busy && master && baud_tick) |=> (st_reg.sck != $past(st_reg.sck)))
      else $error("transfer clock missed a baud tick");

   AST_HIGH_UPPER_ZERO: // RULE_08
   assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      (setup && (idx == `UMSPI_IDX_DIV_HI)) |=> (st_reg.prdata[31:4] == 28'h000_0000))
      else $error("high divisor upper bits not zero");

   AST_ERR_FLAGS_ZERO: // RULE_24
   assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      (setup && (idx == `UMSPI_IDX_STATUS)) |=> (st_reg.prdata[4:2] == 3'b000))
      else $error("receiver error flags read nonzero");

   AST_SCK_IDLE: // RULE_25
   assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      (st_reg.state == UMSPI_IDLE) ##1 (st_reg.state == UMSPI_IDLE)
      |-> (st_reg.sck == $past(pol)))
      else $error("transfer clock not at idle level");

   AST_MOSI_IDLE_HIGH: // RULE_14
   assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      (st_reg.state == UMSPI_IDLE) ##1 (st_reg.state == UMSPI_IDLE) |-> st_reg.mosi)
      else $error("data line not high while idle");

   AST_TXC_AFTER_DRAIN: // RULE_15
   assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      $rose(st_reg.txc) |-> (!st_reg.tx_full && ($past(st_reg.state) == UMSPI_XFER)))
      else $error("transmit complete with data still queued");

   AST_RX_NEEDS_TX: // RULE_18
   assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      $rose(st_reg.rxc) |-> $past(rx_on))
      else $error("receive complete without both enables");

   AST_WRITE_QUEUES: // RULE_23
   assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      (access && apb_i.pwrite && (idx == `UMSPI_IDX_DATA) && !st_reg.tx_full
       && st_reg.ctrl_b[`UMSPI_BIT_TXEN])
      |=> (st_reg.tx_full || (st_reg.state == UMSPI_XFER)))
      else $error("data write did not queue a frame");

   AST_MOSI_STILL_ON_SAMPLE: // RULE_10
   assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      (busy && master && baud_tick && ((!st_reg.edge_cnt[0]) ^ pha))
      |=> $stable(st_reg.mosi))
      else $error("data line changed on a sampling edge");

   AST_LEAVE_MODE_ABORTS: // RULE_02
   assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      !master |=> (!busy && (st_reg.sck == $past(pol)) && st_reg.mosi))
      else $error("engine active outside master spi mode");

   AST_FIRST_BIT_ORDER: // RULE_21
   assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      (!busy && master && baud_tick && st_reg.tx_full && !pha)
      |=> (st_reg.mosi == ($past(lsb) ? $past(st_reg.tx_buf[0]) : $past(st_reg.tx_buf[7]))))
      else $error("first data bit does not follow the bit order");

   AST_RX_BIT_ORDER: // RULE_13
   assert property (@(posedge core_clk_i) disable iff (!arst_n_i)
      (busy && master && baud_tick && ((!st_reg.edge_cnt[0]) ^ pha))
      |=> (($past(lsb) ? st_reg.rx_sh[7] : st_reg.rx_sh[0]) == $past(st_reg.in_f)))
      else $error("received bit placed against the bit order");

endmodule
`default_nettype wire

// ### verification/umspi_slave_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// spi slave: samples mosi, shifts a reply byte out on miso
module umspi_slave_model (
   input wire logic sck_i,
   input wire logic mosi_i,
   input wire logic cpol_i,
   input wire logic cpha_i,
   input wire logic lsb_i,
   input wire logic [7:0] resp_i,
   output logic miso_o,
   output logic [7:0] rx_o,
   output var int rx_cnt_o
);
   int s = 0;
   int k = 0;
   logic lead = 1'b0;
   logic [7:0] sh = 8'h00;
   // no select line, so the reply may only change between frames
   assign miso_o = resp_i[lsb_i ? k : 7 - k];
   initial
   begin
      rx_o = 8'h00;
      rx_cnt_o = 0;
   end
   // leading edge samples when phase is 0, trailing edge when phase is 1;
   // a polarity write moves the idle level without a leading edge, so it is skipped
   always @(sck_i)
   begin
      if ((sck_i != cpol_i) || lead)
      begin
         lead = (sck_i != cpol_i);
         if (lead != cpha_i)
         begin
            sh = lsb_i ? {mosi_i, sh[7:1]} : {sh[6:0], mosi_i};
            s = (s + 1) % 8;
            if (s == 0)
            begin
               rx_o = sh;
               rx_cnt_o = rx_cnt_o + 1;
               k = 0;
            end
         end
         else
            k = s;
      end
   end
endmodule
`default_nettype wire

// ### verification/umspi_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "umspi_cfg.svh"
module umspi_top_tb;
   import umspi_pkg::*;
   localparam int DIV = 5;
   logic core_clk_i;
   logic arst_n_i;
   umspi_apb_req_t req;
   umspi_apb_rsp_t rsp;
   logic miso, mosi, mosi_oe_n, sck, sck_oe_n, cpol, cpha, lsb, rx_on, sck_q;
   logic [7:0] resp, slv_rx, tx;
   logic [31:0] rd_q, seed;
   logic rd_e;
   int slv_cnt, bad_count, samples_checked, gap, half, c0;
   logic [7:0] txq[$];
   logic [7:0] rxq[$];
   umspi_top umspi_top_i (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .apb_i(req),
      .apb_o(rsp), .serial_in_i(miso), .serial_out_o(mosi), .serial_out_oe_n_o(mosi_oe_n),
      .sck_o(sck), .sck_oe_n_o(sck_oe_n));
   umspi_slave_model umspi_slave_model_i (.sck_i(sck), .mosi_i(mosi), .cpol_i(cpol),
      .cpha_i(cpha), .lsb_i(lsb), .resp_i(resp), .miso_o(miso), .rx_o(slv_rx),
      .rx_cnt_o(slv_cnt));
   initial
   begin
      core_clk_i = 1'b0;
      forever #50 core_clk_i = ~core_clk_i;
   end
   // half period of the transfer clock, in system cycles
   always @(posedge core_clk_i)
   begin
      sck_q <= sck;
      if (sck !== sck_q)
      begin
         half <= gap;
         gap <= 1;
      end
      else
         gap <= gap + 1;
   end
   function automatic logic [7:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed[7:0];
   endfunction
   task complete_run();
      $display("checked %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] x);
      samples_checked++;
      if (g !== x)
      begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
      end
   endtask
   task apb(input logic w, input logic [9:0] i, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge core_clk_i);
      req <= '{1'b1, 1'b0, w, {i, 2'b00}, {24'h0000, d}};
      @(posedge core_clk_i);
      req.penable <= 1'b1;
      do
      begin
         @(posedge core_clk_i);
         n++;
      end
      while (rsp.pready !== 1'b1 && n < 50);
      rd_q = rsp.prdata;
      rd_e = rsp.pslverr;
      req <= '0;
      if (rsp.pready !== 1'b1)
      begin
         bad_count++;
         complete_run();
      end
   endtask
   task wr(input logic [9:0] i, input logic [7:0] d);
      apb(1'b1, i, d);
   endtask
   task rd(input logic [9:0] i);
      apb(1'b0, i, 8'h00);
   endtask
   task wait_flag(input int b);
      int n;
      n = 0;
      do
      begin
         rd(`UMSPI_IDX_STATUS);
         n++;
      end
      while (rd_q[b] !== 1'b1 && n < 800);
      if (rd_q[b] !== 1'b1)
      begin
         bad_count++;
         complete_run();
      end
   endtask
   task settle();
      repeat (2) @(negedge core_clk_i);
   endtask
   task send(input logic [7:0] d);
      wr(`UMSPI_IDX_DATA, d);
      txq.push_back(d);
      if (rx_on)
         rxq.push_back(resp);
   endtask
   task chk_rx();
      rd(`UMSPI_IDX_DATA);
      chk(rd_q, {24'h0000, rxq.pop_front()});
   endtask
   task chk_slave();
      chk({24'h0000, slv_rx}, {24'h0000, txq.pop_front()});
   endtask
   task tdone(input string s);
      $display("test %s done", s);
   endtask
   initial
   begin
      // ==========================================
      // reset and register defaults
      arst_n_i = 1'b0;
      req = '0;
      {cpol, cpha, lsb, rx_on} = 4'h0;
      resp = 8'h00;
      seed = 32'h0000_43a0;
      bad_count = 0;
      samples_checked = 0;
      repeat (4) @(posedge core_clk_i);
      arst_n_i <= 1'b1;
      rd(`UMSPI_IDX_CTRL_B);
      chk(rd_q, 32'h0000_0000);
      rd(`UMSPI_IDX_CTRL_C);
      chk(rd_q, 32'h0000_0006);
      rd(`UMSPI_IDX_DIV_LO);
      chk(rd_q, 32'h0000_0000);
      rd(`UMSPI_IDX_STATUS);
      chk(rd_q, 32'h0000_0020);
      rd(10'h0C7);
      chk({31'h0, rd_e}, 32'h0000_0001);
      chk({31'h0, sck_oe_n}, 32'h0000_0001);
      tdone("reset");
      // ==========================================
      // init: clock pin first, divisor zero at enable, divisor after
      wr(`UMSPI_IDX_PIN, 8'h01);
      wr(`UMSPI_IDX_CTRL_C, 8'hC0);
      wr(`UMSPI_IDX_CTRL_B, 8'h18);
      rx_on = 1'b1;
      wr(`UMSPI_IDX_DIV_HI, 8'hF0);
      rd(`UMSPI_IDX_DIV_HI);
      chk(rd_q, 32'h0000_0000);
      wr(`UMSPI_IDX_DIV_LO, DIV[7:0]);
      settle();
      chk({30'h0, sck_oe_n, mosi_oe_n}, 32'h0000_0000);
      tdone("init");
      // ==========================================
      // every mode and both bit orders, random data both ways
      for (int m = 0; m < 8; m++)
      begin
         {lsb, cpha, cpol} = m[2:0];
         wr(`UMSPI_IDX_CTRL_C, {5'b11000, lsb, cpha, cpol});
         settle();
         chk({31'h0, sck}, {31'h0, cpol});
         resp = xs();
         wr(`UMSPI_IDX_STATUS, 8'h40);
         send(xs());
         wait_flag(7);
         chk_rx();
         chk_slave();
         chk(half, DIV + 1);
         wait_flag(6);
         chk({29'h0, rd_q[4:2]}, 32'h0000_0000);
         settle();
         chk({30'h0, mosi, sck}, {30'h0, 1'b1, cpol});
      end
      tdone("modes");
      // ==========================================
      // two bytes back to back: completion only after both
      resp = xs();
      wr(`UMSPI_IDX_STATUS, 8'h40);
      send(xs());
      wait_flag(5);
      send(xs());
      wait_flag(7);
      chk({31'h0, rd_q[6]}, 32'h0000_0000);
      chk_rx();
      chk_slave();
      wait_flag(6);
      chk_slave();
      wait_flag(7);
      chk_rx();
      tdone("sixteen");
      // ==========================================
      // transmitter alone, then receiver alone, then leaving spi mode
      wr(`UMSPI_IDX_CTRL_B, 8'h08);
      rx_on = 1'b0;
      wr(`UMSPI_IDX_STATUS, 8'h40);
      send(xs());
      wait_flag(6);
      chk({31'h0, rd_q[7]}, 32'h0000_0000);
      chk_slave();
      c0 = slv_cnt;
      wr(`UMSPI_IDX_CTRL_B, 8'h10);
      wr(`UMSPI_IDX_DATA, xs());
      repeat (200) @(negedge core_clk_i);
      chk(slv_cnt, c0);
      wr(`UMSPI_IDX_CTRL_C, 8'h80);
      wr(`UMSPI_IDX_CTRL_B, 8'h18);
      wr(`UMSPI_IDX_DATA, xs());
      repeat (200) @(negedge core_clk_i);
      chk(slv_cnt, c0);
      tdone("enables");
      complete_run();
   end
endmodule
`default_nettype wire
